// ---- rtl/twc_pkg.sv ----
// Package: register map, field layout, reset values and timing for the timer block
package twc_pkg;
    // Register byte offsets
    localparam logic [7:0]  TIMER_CONFIG_OFS   = 8'h00;
    localparam logic [7:0]  TIMER_PERIOD_OFS   = 8'h04;
    localparam logic [7:0]  TIMER_WIDTH_OFS    = 8'h08;
    localparam logic [7:0]  TIMER_COUNTER_OFS  = 8'h0c;
    localparam logic [7:0]  SHARED_STATUS_OFS  = 8'h10;
    // Config field positions
    localparam int          MODE_LSB           = 0;
    localparam int          POLARITY_BIT       = 2;
    localparam int          PERIOD_SEL_BIT     = 3;
    localparam int          IRQ_EN_BIT         = 4;
    // Status field positions
    localparam int          ST_IRQ_BIT         = 0;
    localparam int          ST_OVF_BIT         = 1;
    localparam int          ST_EN_BIT          = 2;
    // Mode encodings
    localparam logic [1:0]  MODE_PWM           = 2'h1;
    localparam logic [1:0]  MODE_WIDTH_CAPTURE = 2'h2;
    localparam logic [1:0]  MODE_EXT_EVENT     = 2'h3;
    // Values
    localparam logic [31:0] ZERO_WORD          = 32'h0000_0000;
    localparam logic [31:0] ALL_ONES           = 32'hffff_ffff;
    localparam logic [31:0] ALL_ONES_M1        = 32'hffff_fffe;
    localparam logic [4:0]  CONFIG_RESET       = 5'h00;
    // Start latency in peripheral clocks
    localparam int          START_LATENCY_CYC  = 3;
    localparam logic [1:0]  START_WAIT_LOAD    = 2'(START_LATENCY_CYC - 1);

    typedef enum logic [1:0] {
        TWC_OFF,
        TWC_STARTING,
        TWC_WAIT_FIRST,
        TWC_RUN
    } twc_state_type;

    // Captured AHB address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } twc_aphase_type;
endpackage

// ---- rtl/twc_timer.sv ----
// Timer with width-capture and external-event counting, AHB-Lite register slave
`timescale 1ns/1ps
// How it works
// - Mode 10 selects width capture, pin input
// - Polarity picks leading edge: rise or fall
// - Period and width read-only in capture
// - Captured values are count divided by two
// - Counter zero, held until first leading edge
// - Trailing edge copies half count to width
// - Leading edge copies period, clears counter
// - Period-select chooses which capture raises latch
// - Period reads zero until first measured
// - All-ones count disables, sets overflow, latch
// - Status flags sticky, cleared by writing one
// - First rising edge loads all-ones minus period
// - Rising edges count; end sets latch, reloads
// - Event mode uses rising edges only
// - Event mode ignores period-select, no overflow
// - Own irq line, flags mirrored in status
// - Interrupt disabled means latch never set
// - Timer starts three clocks after enable
// - Disable holds counter; re-enable reinitialises
module twc_timer
    import twc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Timer pin and interrupt
    input  wire logic        timer_input_pin,
    output logic             timer_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [4:0]     timer_config_reg_r;
    logic [31:0]    timer_period_reg_r;
    logic [31:0]    timer_width_reg_r;
    logic [31:0]    timer_counter_reg_r;
    logic           timer_irq_latch_r;
    logic           timer_overflow_flag_r;
    logic           timer_enable_flag_r;
    twc_state_type  state_r;
    logic [1:0]     start_cnt_r;
    logic           sync1_r;
    logic           sync2_r;
    logic           sync3_r;
    twc_aphase_type aph_r;
    logic           wr_go;
    logic           set_en;
    logic           clr_en;
    logic           clr_irq;
    logic           clr_ovf;
    logic           cap_mode;
    logic           evt_mode;
    logic           rise;
    logic           fall;
    logic           lead_edge;
    logic           trail_edge;
    logic           irq_en;
    logic           run;
    logic           wcap_width;
    logic           wcap_period;
    logic           wcap_ovf;
    logic           evt_end;
    logic           irq_set;

    ////////////////////////////////////////////////////////////////////////////////
    // Operating notes for whoever picks this block up next
    //
    // Register map, one aligned word each, only haddr[7:0] decoded:
    //   0x00 config: mode field, polarity, period-select, irq enable
    //   0x04 period, 0x08 width, 0x0c counter (never writable)
    //   0x10 status: irq latch and overflow are write-one-to-clear,
    //        bit 2 enables when written as one and disables as zero
    //
    // Because enable sits in the status word, a flag clear that should
    // leave the timer running must write bit 2 as one as well. The
    // trade was one fewer register against a slightly odd clear idiom.
    //
    // Bus timing:
    //   Zero wait states; hreadyout and hresp are flops held constant.
    //   Read data is latched on the address phase, so it stands for the
    //   whole data phase and until the next read address phase.
    //   Write data is applied at the data-phase edge and is visible on
    //   the following cycle.
    //
    // Start sequence:
    //   The enable write moves the state to STARTING for three clocks.
    //   In capture mode the counter and the period word are cleared
    //   during that time, so a period read before the first full cycle
    //   returns zero.
    //   In event mode nothing is loaded until the first rising edge; the
    //   counter keeps its old value until then.
    //
    // Capture mode:
    //   The first leading edge starts the count. Each clock adds one.
    //   A trailing edge copies half the count into width and lets the
    //   count run on. A leading edge copies half the count into period
    //   and restarts from zero. Halving makes the results match the
    //   units of a waveform generated at twice the register value.
    //   An all-ones count stops the timer and raises overflow; the
    //   counter is frozen there so software can see where it stopped.
    //
    // Event mode:
    //   Only rising edges count, whatever the polarity bit says. The
    //   counter runs from all ones minus period up to all ones minus
    //   one; the rise that finds it there raises the latch and reloads.
    //   The counter may be mid-update when read, so software should
    //   read it only with the timer stopped.
    //
    // Input path:
    //   The pin goes through two flops before edge detection, so every
    //   edge is seen two clocks after the pin moves. The third flop
    //   only remembers the previous synchronised level; nothing reads
    //   the first stage except the second.
    //   Pulses shorter than a clock can be missed; that is a limit of a
    //   single-clock design, not something the logic tries to recover.
    //
    // Flags:
    //   A hardware set and a software clear in the same cycle leave the
    //   flag set, so an event is never lost to a late clear.
    //   With the irq enable bit low the latch never sets, not even on
    //   overflow; the overflow flag itself still records the event.
    //   The dedicated request line is one clock behind the latch so
    //   that it comes straight from a flop.
    //
    // Disable:
    //   Writing enable as zero returns to OFF and freezes the counter.
    //   Re-enabling runs the start sequence again, which is how a
    //   watchdog built on this timer is serviced.
    //
    // Not implemented:
    //   Mode 01 is stored but never decoded and drives nothing; the pin is input only here.
    //   Mode 00 leaves the timer idle apart from register access.
    //   hsize is ignored; every access is taken as a full word.

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aph_r <= '0;
        end else if (hready) begin
            aph_r.valid <= hsel & htrans[1];
            aph_r.write <= hwrite;
            aph_r.addr  <= haddr[7:0];
        end
    end

    // Outputs from flops; readyout never stalls
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign wr_go   = aph_r.valid & aph_r.write;
    assign set_en  = wr_go & (aph_r.addr == SHARED_STATUS_OFS) & hwdata[ST_EN_BIT];
    // Writing zero to the enable bit disables; same word also clears flags
    assign clr_en  = wr_go & (aph_r.addr == SHARED_STATUS_OFS) & ~hwdata[ST_EN_BIT];
    assign clr_irq = wr_go & (aph_r.addr == SHARED_STATUS_OFS) & hwdata[ST_IRQ_BIT];
    assign clr_ovf = wr_go & (aph_r.addr == SHARED_STATUS_OFS) & hwdata[ST_OVF_BIT];

    // Read data registered at the address phase so it stands in the data phase
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hrdata <= ZERO_WORD;
        end else if (hready & hsel & htrans[1] & ~hwrite) begin
            unique case (haddr[7:0])
                TIMER_CONFIG_OFS:  hrdata <= {27'h0, timer_config_reg_r};
                TIMER_PERIOD_OFS:  hrdata <= timer_period_reg_r;
                TIMER_WIDTH_OFS:   hrdata <= timer_width_reg_r;
                // Counter is meaningless while an event count runs
                TIMER_COUNTER_OFS: hrdata <= timer_counter_reg_r;
                SHARED_STATUS_OFS: hrdata <= {29'h0, timer_enable_flag_r,
                                              timer_overflow_flag_r,
                                              timer_irq_latch_r};
                default:           hrdata <= ZERO_WORD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_config_reg_r <= CONFIG_RESET;
        end else if (wr_go & (aph_r.addr == TIMER_CONFIG_OFS)) begin
            timer_config_reg_r <= hwdata[4:0];
        end
    end

    assign cap_mode = timer_config_reg_r[MODE_LSB +: 2] == MODE_WIDTH_CAPTURE;
    assign evt_mode = timer_config_reg_r[MODE_LSB +: 2] == MODE_EXT_EVENT;
    assign irq_en   = timer_config_reg_r[IRQ_EN_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchroniser and edge detect; first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else begin
            sync1_r <= timer_input_pin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    assign rise = sync2_r & ~sync3_r;
    assign fall = ~sync2_r & sync3_r;
    // Polarity only matters in capture mode
    assign lead_edge  = timer_config_reg_r[POLARITY_BIT] ? rise : fall;
    assign trail_edge = timer_config_reg_r[POLARITY_BIT] ? fall : rise;

    ////////////////////////////////////////////////////////////////////////////////
    // Enable sequencing and start latency
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r     <= TWC_OFF;
            start_cnt_r <= 2'h0;
        end else if (clr_en | wcap_ovf) begin
            state_r <= TWC_OFF;
        end else begin
            unique case (state_r)
                TWC_OFF: begin
                    if (set_en) begin
                        state_r     <= TWC_STARTING;
                        start_cnt_r <= START_WAIT_LOAD;
                    end
                end
                TWC_STARTING: begin
                    if (start_cnt_r == 2'h0) begin
                        state_r <= TWC_WAIT_FIRST;
                    end else begin
                        start_cnt_r <= start_cnt_r - 2'h1;
                    end
                end
                TWC_WAIT_FIRST: begin
                    if ((cap_mode & lead_edge) | (evt_mode & rise)) begin
                        state_r <= TWC_RUN;
                    end
                end
                TWC_RUN: begin
                    state_r <= TWC_RUN;
                end
            endcase
        end
    end

    // Enable flag in status mirrors any state other than OFF, registered, set by the enable write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_enable_flag_r <= 1'b0;
        end else begin
            timer_enable_flag_r <= (state_r != TWC_OFF) | set_en;
        end
    end

    assign run = (state_r == TWC_RUN);
    // Width-capture events
    assign wcap_width  = cap_mode & run & trail_edge;
    assign wcap_period = cap_mode & run & lead_edge;
    assign wcap_ovf    = cap_mode & run & (timer_counter_reg_r == ALL_ONES);
    // Event end: counter sits at all ones minus one; overflow never used here
    assign evt_end     = evt_mode & run & rise & (timer_counter_reg_r == ALL_ONES_M1);

    ////////////////////////////////////////////////////////////////////////////////
    // Counter
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_counter_reg_r <= ZERO_WORD;
        end else if (state_r == TWC_STARTING && start_cnt_r == 2'h0) begin
            // Reinitialise on every enable, per mode
            if (cap_mode) begin
                timer_counter_reg_r <= ZERO_WORD;
            end
        end else if (state_r == TWC_WAIT_FIRST && evt_mode && rise) begin
            timer_counter_reg_r <= ALL_ONES - timer_period_reg_r;
        end else if (run && cap_mode && !wcap_ovf) begin
            // Leading edge restarts measurement; width capture keeps counting
            timer_counter_reg_r <= wcap_period ? ZERO_WORD
                                               : timer_counter_reg_r + 32'h1;
        end else if (run && evt_mode && rise) begin
            timer_counter_reg_r <= (timer_counter_reg_r == ALL_ONES_M1)
                                   ? ALL_ONES - timer_period_reg_r
                                   : timer_counter_reg_r + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Period software-writable except in capture mode; width also read-only in event mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_period_reg_r <= ZERO_WORD;
        end else if (cap_mode) begin
            if (state_r == TWC_STARTING) begin
                timer_period_reg_r <= ZERO_WORD;
            end else if (wcap_period) begin
                timer_period_reg_r <= {1'b0, timer_counter_reg_r[31:1]};
            end
        end else if (wr_go & (aph_r.addr == TIMER_PERIOD_OFS)) begin
            timer_period_reg_r <= hwdata;
        end
    end

    // Width is unused in event mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_width_reg_r <= ZERO_WORD;
        end else if (cap_mode) begin
            if (wcap_width) begin
                timer_width_reg_r <= {1'b0, timer_counter_reg_r[31:1]};
            end
        end else if (!evt_mode && wr_go && aph_r.addr == TIMER_WIDTH_OFS) begin
            timer_width_reg_r <= hwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky status flags; a set in the same cycle as a clear wins
    assign irq_set = irq_en & (wcap_ovf | evt_end |
                     (timer_config_reg_r[PERIOD_SEL_BIT] ? wcap_period
                                                         : wcap_width));

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_irq_latch_r <= 1'b0;
        end else if (irq_set) begin
            timer_irq_latch_r <= 1'b1;
        end else if (clr_irq) begin
            timer_irq_latch_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_overflow_flag_r <= 1'b0;
        end else if (wcap_ovf) begin
            timer_overflow_flag_r <= 1'b1;
        end else if (clr_ovf) begin
            timer_overflow_flag_r <= 1'b0;
        end
    end

    // Dedicated request line follows the latch one clock later
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= timer_irq_latch_r;
        end
    end

endmodule // twc_timer

// ---- verif/twc_timer_monitor.sv ----
// Port-level checker for the timer block
`timescale 1ns/1ps
module twc_timer_monitor
    import twc_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Interrupt
    input wire logic        timer_irq
);
    logic       rd_ap;
    logic       wr_ap;
    logic       wd_r;
    logic [7:0] wa_r;
    logic [4:0] cfg_r;
    logic [3:0] st_wr_r;
    assign rd_ap = hsel && hready && htrans[1] && !hwrite;
    assign wr_ap = hsel && hready && htrans[1] && hwrite;
    // Shadow config and recent status writes; hwdata is only valid one edge after the address
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wd_r    <= 1'b0;
            wa_r    <= 8'h00;
            cfg_r   <= 5'h00;
            st_wr_r <= 4'h0;
        end else begin
            wd_r    <= wr_ap;
            wa_r    <= wr_ap ? haddr[7:0] : wa_r;
            cfg_r   <= (wd_r && wa_r == TIMER_CONFIG_OFS) ? hwdata[4:0] : cfg_r;
            st_wr_r <= {st_wr_r[2:0], wd_r && wa_r == SHARED_STATUS_OFS};
        end
    end
    ////////////////////////////////////////
    AST_READY: assert property (@(posedge sys_clk) disable iff (rst) hreadyout)
        else $error("slave inserted a wait state");
    AST_OKAY: assert property (@(posedge sys_clk) disable iff (rst) !hresp)
        else $error("slave gave an error response");
    AST_RST_VAL: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(rst) |-> hrdata == ZERO_WORD && !timer_irq) else $error("bad value after reset");
    AST_UNMAPPED: assert property (@(posedge sys_clk) disable iff (rst)
        rd_ap && haddr[7:0] > SHARED_STATUS_OFS |=> hrdata == ZERO_WORD)
        else $error("unmapped read not zero");
    AST_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        !rd_ap |=> $stable(hrdata)) else $error("read data changed without a read");
    AST_STICKY: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(timer_irq) |-> |st_wr_r) else $error("irq dropped without a status write");
    AST_IRQ_GATE: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(timer_irq) |-> $past(cfg_r[IRQ_EN_BIT], 2)) else $error("irq rose while disabled");
    AST_CFG_RD: assert property (@(posedge sys_clk) disable iff (rst)
        rd_ap && haddr[7:0] == TIMER_CONFIG_OFS ##1 1'b1 |-> hrdata[4:0] == $past(cfg_r))
        else $error("config read back differs");
endmodule // twc_timer_monitor

bind twc_timer twc_timer_monitor i_twc_timer_monitor (.sys_clk(sys_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_irq(timer_irq));

// ---- verif/twc_timer_tb.sv ----
// Self-checking bench for the timer block
`timescale 1ns/1ps
module twc_timer_tb
    import twc_pkg::*;
;
    logic        sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, run = 0, idle_lvl = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic [1:0]  htrans = 0;
    logic [7:0]  hi_c = 8'h15, lo_c = 8'h1e;
    logic        hreadyout, hresp, timer_irq, pin;
    int          failures = 0, tests_run = 0, rises = 0;
    always #4 sys_clk = ~sys_clk;
    always @(posedge pin) rises++;
    twc_timer i_twc_timer (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_input_pin(pin),
        .timer_irq(timer_irq));
    twc_wave_src i_twc_wave_src (.sys_clk(sys_clk), .run(run), .idle_lvl(idle_lvl),
        .hi_cyc(hi_c), .lo_cyc(lo_c), .pin(pin));
    ////////////////////////////////////////
    task print_verdict;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One single transfer; read data is taken at the data-phase edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; hwrite <= w; haddr <= {24'h0, a}; htrans <= 2'h2;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0; hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        q = hrdata;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, ZERO_WORD);
        chk(q, exp);
    endtask
    task wait_irq;
        for (int n = 0; n < 400 && timer_irq !== 1'b1; n++) @(posedge sys_clk);
    endtask
    // Start timer: config, two idle slots, then enable, then the waveform
    task start(input logic [31:0] cfg, input logic lvl, input logic [7:0] h, input logic [7:0] l);
        idle_lvl <= lvl; hi_c <= h; lo_c <= l;
        bus(1'b1, TIMER_CONFIG_OFS, cfg);
        repeat (2) @(posedge sys_clk);
        bus(1'b1, SHARED_STATUS_OFS, 32'h4);
        run <= 1'b1;
    endtask
    task stop;
        run <= 1'b0;
        bus(1'b1, SHARED_STATUS_OFS, 32'h3); // Clear both flags and disable
    endtask
    ////////////////////////////////////////
    task t_reset;
        for (int i = 0; i < 6; i++) rdc(8'(i * 4), ZERO_WORD);
        bus(1'b1, TIMER_COUNTER_OFS, 32'h1234);
        rdc(TIMER_COUNTER_OFS, ZERO_WORD);
    endtask
    // Odd pulse lengths so an off-by-one count still halves to the same value
    task t_cap_high;
        start(32'h16, 1'b0, 8'd21, 8'd30);
        wait_irq;
        chk(32'(timer_irq), 32'h1);
        rdc(TIMER_WIDTH_OFS, 32'd10);
        rdc(TIMER_PERIOD_OFS, ZERO_WORD);
        bus(1'b1, TIMER_PERIOD_OFS, 32'h55);
        bus(1'b1, SHARED_STATUS_OFS, 32'h5);
        repeat (2) @(posedge sys_clk);
        chk(32'(timer_irq), 32'h0);
        wait_irq;
        rdc(TIMER_PERIOD_OFS, 32'd25);
        rdc(SHARED_STATUS_OFS, 32'h5);
        stop;
    endtask
    task t_cap_low;
        start(32'h1a, 1'b1, 8'd30, 8'd21);
        wait_irq;
        rdc(TIMER_PERIOD_OFS, 32'd25);
        rdc(TIMER_WIDTH_OFS, 32'd10);
        stop;
    endtask
    task t_no_irq;
        start(32'h06, 1'b0, 8'd21, 8'd30);
        repeat (150) @(posedge sys_clk);
        chk(32'(timer_irq), 32'h0);
        rdc(SHARED_STATUS_OFS, 32'h4);
        rdc(TIMER_WIDTH_OFS, 32'd10);
        stop;
    endtask
    // Event counting with polarity clear and period-select set, neither of which may matter
    // Mode goes to event first: in capture mode the period write would be dropped
    task t_event;
        bus(1'b1, TIMER_CONFIG_OFS, 32'h1b);
        bus(1'b1, TIMER_PERIOD_OFS, 32'h3);
        start(32'h1b, 1'b0, 8'd2, 8'd3);
        rises = 0;
        while (rises < 3) @(posedge sys_clk);
        run <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk(32'(timer_irq), 32'h0);
        run <= 1'b1;
        while (rises < 4) @(posedge sys_clk);
        run <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk(32'(timer_irq), 32'h1);
        rdc(SHARED_STATUS_OFS, 32'h5);
        bus(1'b1, SHARED_STATUS_OFS, 32'h3);
        rdc(TIMER_COUNTER_OFS, 32'hffff_fffc);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset;
        t_cap_high;
        t_cap_low;
        t_no_irq;
        t_event;
        print_verdict;
    end
    // Whole run is about 450 cycles; stop a hang well past that
    initial begin
        #40000;
        failures++;
        print_verdict;
    end
endmodule // twc_timer_tb

// ---- verif/twc_wave_src.sv ----
// Rectangular waveform source standing on the timer input pin
`timescale 1ns/1ps
module twc_wave_src (
    // Clock and control
    input  wire logic       sys_clk,
    input  wire logic       run,
    input  wire logic       idle_lvl,
    input  wire logic [7:0] hi_cyc,
    input  wire logic [7:0] lo_cyc,
    // Pin
    output logic            pin
);
    logic [7:0] cnt_r;
    logic       lvl_r;
    // Pin is always driven; it rests at idle level, so stopping away from idle makes one edge back to it
    always_ff @(posedge sys_clk) begin
        if (!run) begin
            cnt_r <= 8'h01;
            lvl_r <= idle_lvl;
        end else if (cnt_r >= (lvl_r ? hi_cyc : lo_cyc)) begin
            cnt_r <= 8'h01;
            lvl_r <= !lvl_r;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    assign pin = lvl_r;
endmodule // twc_wave_src
